// ---- flag_branch_consts.vh ----
/*
  Constants for the flag test and branch unit: register byte offsets, control
  field positions, operation codes, flag bit positions and reset values.
  Assumes it is included by its bare name from the unit's design file.
*/
`ifndef FLAG_BRANCH_CONSTS_VH
`define FLAG_BRANCH_CONSTS_VH

// ----------------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_IP 8'h08
`define OFS_CS 8'h0C
`define OFS_SP 8'h10
`define OFS_FLAGS 8'h14
`define OFS_OPA 8'h18
`define OFS_OPB 8'h1C
`define OFS_DISP 8'h20
`define OFS_TARGET 8'h24
`define OFS_SELECTOR 8'h28
`define OFS_IMM 8'h2C

// ----------------------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------------------
`define CTRL_OP_LSB 0
`define CTRL_OP_MSB 3
`define CTRL_CC_LSB 4
`define CTRL_CC_MSB 7
`define CTRL_SHORT_BIT 8
`define CTRL_PMODE_BIT 9
`define CTRL_GATE_LSB 10
`define CTRL_GATE_MSB 11

// ----------------------------------------------------------------------------
// operation codes
// ----------------------------------------------------------------------------
`define OP_SET_BYTE 4'h0
`define OP_TEST 4'h1
`define OP_JMP_REL 4'h2
`define OP_JMP_REG 4'h3
`define OP_JMP_MEM_NEAR 4'h4
`define OP_JMP_MEM_FAR 4'h5
`define OP_CALL_REL 4'h6
`define OP_CALL_NEAR 4'h7
`define OP_CALL_FAR 4'h8
`define OP_RET 4'h9
`define OP_RET_IMM 4'hA
`define OP_INT_ENTRY 4'hB
`define OP_INTERRUPT_RETURN 4'hC
`define OP_JCC_REL 4'hD
`define OP_JMP_GATE 4'hE

// ----------------------------------------------------------------------------
// gate kinds, flag bits, stack step, reset values
// ----------------------------------------------------------------------------
`define GATE_CALL 2'h1
`define GATE_TASK 2'h2
`define GATE_TSS 2'h3
`define FLAG_CARRY 0
`define FLAG_PARITY 2
`define FLAG_ZERO 6
`define FLAG_SIGN 7
`define FLAG_OVERFLOW 11
`define STACK_STEP 32'h0000_0004
`define RST_WORD 32'h0000_0000
`define RST_FLAGS 32'h0000_0002

`endif

// ---- flag_test_and_branch_unit.v ----
/*
  Flag test and branch unit: byte set on condition, non-destructive AND test,
  jumps, calls, returns, interrupt entry and interrupt return, driven from an
  AHB-Lite register file, with stack traffic on a simple load/store port.
  Assumes a single AHB-Lite master issuing single word transfers, and a memory
  port that answers each request with a one-cycle mem_ack pulse.
*/
`timescale 1ns/10ps
`include "flag_branch_consts.vh"

module flag_test_and_branch_unit (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // ahb-lite slave
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output wire hreadyout,
  output wire hresp,
  output reg [31:0] hrdata,
  // stack memory port
  output reg mem_req,
  output reg mem_write,
  output reg [31:0] mem_addr,
  output reg [31:0] mem_wdata,
  input wire [31:0] mem_rdata,
  input wire mem_ack
);

  // --------------------------------------------------------------------------
  // state codes and item codes
  // --------------------------------------------------------------------------
  localparam S_IDLE = 2'd0;
  localparam S_ISSUE = 2'd1;
  localparam S_WAIT = 2'd2;
  localparam IT_IP = 2'd0;
  localparam IT_CS = 2'd1;
  localparam IT_FLAGS = 2'd2;

  // --------------------------------------------------------------------------
  // functions
  // --------------------------------------------------------------------------
  // condition evaluator over the flags word
  function cond_true;
    input [3:0] cc;
    input [31:0] f;
    reg base;
    begin
      case (cc[3:1])
        3'd0: base = f[`FLAG_OVERFLOW];
        3'd1: base = f[`FLAG_CARRY];
        3'd2: base = f[`FLAG_ZERO];
        3'd3: base = f[`FLAG_CARRY] | f[`FLAG_ZERO];
        3'd4: base = f[`FLAG_SIGN];
        3'd5: base = f[`FLAG_PARITY];
        3'd6: base = f[`FLAG_SIGN] ^ f[`FLAG_OVERFLOW];
        3'd7: base = (f[`FLAG_SIGN] ^ f[`FLAG_OVERFLOW]) | f[`FLAG_ZERO];
        default: base = 1'b0;
      endcase
      cond_true = base ^ cc[0]; // odd suffix negates
    end
  endfunction

  // number of stack items an operation moves
  function [1:0] item_count;
    input [3:0] op;
    begin
      case (op)
        `OP_CALL_REL, `OP_CALL_NEAR, `OP_RET, `OP_RET_IMM: item_count = 2'd1;
        `OP_CALL_FAR: item_count = 2'd2;
        `OP_INT_ENTRY, `OP_INTERRUPT_RETURN: item_count = 2'd3;
        default: item_count = 2'd0;
      endcase
    end
  endfunction

  // which word the step moves, in stack order
  function [1:0] item_kind;
    input [3:0] op;
    input [1:0] idx;
    begin
      case (op)
        `OP_INT_ENTRY: item_kind = (idx == 2'd0) ? IT_FLAGS : ((idx == 2'd1) ? IT_CS : IT_IP);
        `OP_CALL_FAR: item_kind = (idx == 2'd0) ? IT_CS : IT_IP;
        `OP_INTERRUPT_RETURN: item_kind = (idx == 2'd0) ? IT_IP : ((idx == 2'd1) ? IT_CS : IT_FLAGS);
        default: item_kind = IT_IP;
      endcase
    end
  endfunction

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  reg [1:0] state;
  reg [3:0] cur_op;
  reg [1:0] idx;
  reg [31:0] ip;
  reg [15:0] cs;
  reg [31:0] sp;
  reg [31:0] flags;
  reg [31:0] opa;
  reg [31:0] opb;
  reg [31:0] disp;
  reg [31:0] target;
  reg [15:0] selector;
  reg [15:0] imm;
  reg [11:0] ctrl_last;
  reg [7:0] result_byte;
  reg taken;
  reg [1:0] gate_seen;
  reg [31:0] pend_ip;
  reg [15:0] pend_cs;
  reg dp_write;
  reg [7:0] dp_addr;

  wire addr_phase = hsel & hready & htrans[1];
  wire busy = (state != S_IDLE);
  wire ctrl_write = dp_write & (dp_addr == `OFS_CTRL) & ~busy;
  wire [3:0] w_op = hwdata[`CTRL_OP_MSB:`CTRL_OP_LSB];
  wire [3:0] w_cc = hwdata[`CTRL_CC_MSB:`CTRL_CC_LSB];
  wire [1:0] w_gate = hwdata[`CTRL_GATE_MSB:`CTRL_GATE_LSB];
  wire w_pmode = hwdata[`CTRL_PMODE_BIT];
  wire w_cond = cond_true(w_cc, flags);
  // displacement, short form sign-extended from its low byte
  wire [31:0] sx_disp = hwdata[`CTRL_SHORT_BIT] ? {{24{disp[7]}}, disp[7:0]} : disp;
  wire [31:0] rel_ip = ip + sx_disp;
  wire [31:0] and_res = opa & opb;
  wire [1:0] cur_kind = item_kind(cur_op, idx);
  wire cur_push = (cur_op == `OP_CALL_REL) | (cur_op == `OP_CALL_NEAR) |
                  (cur_op == `OP_CALL_FAR) | (cur_op == `OP_INT_ENTRY);
  wire [1:0] cur_count = item_count(cur_op);

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // --------------------------------------------------------------------------
  // bus address phase capture and read data
  // --------------------------------------------------------------------------
  // read data is loaded at the address phase edge and stands in the data phase
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_write <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= `RST_WORD;
    end else begin
      // writes outside the decoded page are dropped, not aliased onto the low offsets
      dp_write <= addr_phase & hwrite & (haddr[31:8] == 24'h000000);
      dp_addr <= haddr[7:0];
      if (addr_phase & ~hwrite) begin
        if (haddr[31:8] != 24'h000000) begin
          hrdata <= 32'h0000_0000;
        end else begin
          case (haddr[7:0])
            `OFS_CTRL: hrdata <= {20'h00000, ctrl_last};
            `OFS_STATUS: hrdata <= {16'h0000, result_byte, 3'b000, gate_seen, 1'b0, taken, busy};
            `OFS_IP: hrdata <= ip;
            `OFS_CS: hrdata <= {16'h0000, cs};
            `OFS_SP: hrdata <= sp;
            `OFS_FLAGS: hrdata <= flags;
            `OFS_OPA: hrdata <= opa;
            `OFS_OPB: hrdata <= opb;
            `OFS_DISP: hrdata <= disp;
            `OFS_TARGET: hrdata <= target;
            `OFS_SELECTOR: hrdata <= {16'h0000, selector};
            `OFS_IMM: hrdata <= {16'h0000, imm};
            default: hrdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  // --------------------------------------------------------------------------
  // architectural state, operation start and stack engine
  // --------------------------------------------------------------------------
  // bus writes land in the data phase; writes while busy are ignored
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state <= S_IDLE;
      cur_op <= 4'h0;
      idx <= 2'd0;
      ip <= `RST_WORD;
      cs <= 16'h0000;
      sp <= `RST_WORD;
      flags <= `RST_FLAGS;
      opa <= `RST_WORD;
      opb <= `RST_WORD;
      disp <= `RST_WORD;
      target <= `RST_WORD;
      selector <= 16'h0000;
      imm <= 16'h0000;
      ctrl_last <= 12'h000;
      result_byte <= 8'h00;
      taken <= 1'b0;
      gate_seen <= 2'b00;
      pend_ip <= `RST_WORD;
      pend_cs <= 16'h0000;
      mem_req <= 1'b0;
      mem_write <= 1'b0;
      mem_addr <= `RST_WORD;
      mem_wdata <= `RST_WORD;
    end else begin
      case (state)
        S_IDLE: begin
          if (dp_write & (dp_addr[7:0] != `OFS_CTRL) & (dp_addr != `OFS_STATUS)) begin
            case (dp_addr)
              `OFS_IP: ip <= hwdata;
              `OFS_CS: cs <= hwdata[15:0];
              `OFS_SP: sp <= hwdata;
              `OFS_FLAGS: flags <= hwdata;
              `OFS_OPA: opa <= hwdata;
              `OFS_OPB: opb <= hwdata;
              `OFS_DISP: disp <= hwdata;
              `OFS_TARGET: target <= hwdata;
              `OFS_SELECTOR: selector <= hwdata[15:0];
              `OFS_IMM: imm <= hwdata[15:0];
              default: ;
            endcase
          end
          if (ctrl_write) begin
            ctrl_last <= hwdata[11:0];
            cur_op <= w_op;
            idx <= 2'd0;
            taken <= 1'b0;
            gate_seen <= 2'b00;
            case (w_op)
              `OP_SET_BYTE: result_byte <= {7'h00, w_cond};
              `OP_TEST: begin
                // operands untouched, AND result not kept
                flags[`FLAG_SIGN] <= and_res[31];
                flags[`FLAG_ZERO] <= (and_res == 32'h0000_0000);
                flags[`FLAG_PARITY] <= ~^and_res[7:0];
              end
              `OP_JCC_REL: begin
                taken <= w_cond;
                if (w_cond) begin
                  ip <= rel_ip;
                end
              end
              // plain jumps load ip, and also cs for the far form; nothing goes to the stack
              `OP_JMP_REL: begin
                taken <= 1'b1;
                ip <= rel_ip;
              end
              `OP_JMP_REG, `OP_JMP_MEM_NEAR: begin
                taken <= 1'b1;
                ip <= target;
              end
              `OP_JMP_MEM_FAR: begin
                taken <= 1'b1;
                cs <= selector;
                ip <= target;
              end
              `OP_JMP_GATE: begin
                taken <= 1'b1;
                // in protected mode, task gates and task segments are reported for the task switch logic
                gate_seen <= w_pmode ? w_gate : 2'b00;
                if (!w_pmode || (w_gate != `GATE_TASK && w_gate != `GATE_TSS)) begin
                  cs <= selector;
                  ip <= target;
                end
              end
              `OP_CALL_REL, `OP_CALL_NEAR, `OP_CALL_FAR, `OP_INT_ENTRY, `OP_RET, `OP_RET_IMM, `OP_INTERRUPT_RETURN: begin
                taken <= 1'b1;
                state <= S_ISSUE;
                pend_ip <= (w_op == `OP_CALL_REL) ? rel_ip : target;
                pend_cs <= ((w_op == `OP_CALL_FAR) | (w_op == `OP_INT_ENTRY)) ? selector : cs;
              end
              default: ;
            endcase
          end
        end
        S_ISSUE: begin
          mem_req <= 1'b1;
          mem_write <= cur_push;
          if (cur_push) begin
            sp <= sp - `STACK_STEP;
            mem_addr <= sp - `STACK_STEP;
            case (cur_kind)
              IT_FLAGS: mem_wdata <= flags;
              IT_CS: mem_wdata <= {16'h0000, cs};
              default: mem_wdata <= ip; // ip already holds the next instruction
            endcase
          end else begin
            mem_addr <= sp;
          end
          state <= S_WAIT;
        end
        S_WAIT: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            mem_write <= 1'b0;
            if (!cur_push) begin
              sp <= sp + `STACK_STEP;
              case (cur_kind)
                IT_FLAGS: flags <= mem_rdata;
                IT_CS: cs <= mem_rdata[15:0];
                default: ip <= mem_rdata;
              endcase
            end
            if (idx == cur_count - 2'd1) begin
              state <= S_IDLE;
              if (cur_push) begin
                ip <= pend_ip; // target loaded only after the return pointer is stored
                cs <= pend_cs;
              end
              if (cur_op == `OP_RET_IMM) begin
                sp <= sp + `STACK_STEP + {16'h0000, imm};
              end
            end else begin
              idx <= idx + 2'd1;
              state <= S_ISSUE;
            end
          end
        end
        default: state <= S_IDLE;
      endcase
    end
  end

endmodule // flag_test_and_branch_unit

// ---- flag_test_and_branch_unit_checker.sv ----
/* port checker for the flag test and branch unit.
   assumes a bind from the bench top file. */
`timescale 1ns/10ps
module flag_test_and_branch_unit_checker (
  // clock and reset
  input wire hclk,
  input wire hresetn,
  // register bus
  input wire hsel,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // stack port
  input wire mem_req,
  input wire mem_write,
  input wire [31:0] mem_addr,
  input wire [31:0] mem_wdata,
  input wire mem_ack
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ---------------------------------------------------------------
  // bus and stack port relations
  // ---------------------------------------------------------------
  chk_ready_high: assert property (hreadyout) else $error("wait state seen");
  chk_resp_okay: assert property (!hresp) else $error("error response seen");
  chk_rdata_stand: assert property (!(hsel && htrans[1] && !hwrite && hready) |=> $stable(hrdata))
    else $error("read data moved");
  chk_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("stack request dropped early");
  chk_write_hold: assert property (mem_req && !mem_ack |=> $stable(mem_write) && $stable(mem_wdata))
    else $error("stack write data moved");
  chk_req_drop: assert property (mem_req && mem_ack |=> !mem_req)
    else $error("stack request held after ack");
  chk_push_step: assert property ((mem_req && mem_write && mem_ack) ##1 !mem_req
    ##1 (mem_req && mem_write) |-> mem_addr == $past(mem_addr, 2) - 32'h4) else $error("push step wrong");
  chk_pop_step: assert property ((mem_req && !mem_write && mem_ack) ##1 !mem_req
    ##1 (mem_req && !mem_write) |-> mem_addr == $past(mem_addr, 2) + 32'h4) else $error("pop step wrong");
endmodule // flag_test_and_branch_unit_checker

// ---- flag_test_and_branch_unit_tb.sv ----
/* self-checking bench for the flag test and branch unit.
   assumes the unit and its constants header are compiled alongside. */
`timescale 1ns/10ps
`include "flag_branch_consts.vh"
module flag_test_and_branch_unit_tb;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, mem_ack = 0, pr = 0;
  logic [31:0] haddr = 0, hwdata = 0, mem_rdata = 0, ip, cs, sp, fl, q, v, w, r, o;
  logic [1:0] htrans = 0;
  logic [2:0] hsize = 3'h2;
  wire hready, hreadyout, hresp, mem_req, mem_write;
  wire [31:0] hrdata, mem_addr, mem_wdata;
  int num_errors = 0, n_checks = 0, n_req = 0, wt = 0, n0, seed = 32'h6E964D22;
  logic [31:0] stk [logic [31:0]];
  assign hready = hreadyout;
  // clock
  always #2.5 hclk = ~hclk;
  flag_test_and_branch_unit dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .mem_ack(mem_ack));
  // stack memory: random wait, one ack pulse, noise when idle
  always @(posedge hclk) begin
    pr <= mem_req;
    if (mem_req && !pr) n_req <= n_req + 1;
    if (mem_req && !mem_ack && wt == 0) begin
      mem_ack <= 1'b1;
      if (mem_write) stk[mem_addr] = mem_wdata;
      mem_rdata <= stk.exists(mem_addr) ? stk[mem_addr] : 32'h0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= $random(seed);
      wt <= (mem_req && !mem_ack) ? wt - 1 : {$random(seed)} % 3;
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one single ahb-lite transfer; read data lands in q
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    q = hrdata;
  endtask
  task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(nm, q, e);
  endtask
  task automatic run(input logic [31:0] c);
    bus(1'b1, `OFS_CTRL, c);
    for (int i = 0; i < 100; i++) begin
      bus(1'b0, `OFS_STATUS, 32'h0);
      if (q[0] === 1'b0) break;
    end
    chk("busy", {31'h0, q[0]}, 32'h0);
  endtask
  task automatic regs();
    rchk("ip", `OFS_IP, ip);
    rchk("cs", `OFS_CS, cs);
    rchk("sp", `OFS_SP, sp);
    rchk("flags", `OFS_FLAGS, fl);
  endtask
  function automatic logic cond(input logic [3:0] c, input logic [31:0] f);
    logic t;
    case (c[3:1])
      3'h0: t = f[11];
      3'h1: t = f[0];
      3'h2: t = f[6];
      3'h3: t = f[0] | f[6];
      3'h4: t = f[7];
      3'h5: t = f[2];
      3'h6: t = f[7] ^ f[11];
      default: t = (f[7] ^ f[11]) | f[6];
    endcase
    return t ^ c[0];
  endfunction
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // watchdog
  initial begin
    #200000;
    num_errors++;
    conclude();
  end
  // main sequence
  initial begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    ip = 0; cs = 0; sp = 0; fl = 32'h2;
    regs();
    bus(1'b1, 8'h30, 32'h5A5A5A5A);
    rchk("unmapped", 8'h30, 32'h0);
    for (int c = 0; c < 32; c++) begin
      v = $random(seed);
      bus(1'b1, `OFS_FLAGS, v);
      run({24'h0, c[3:0], 4'h0});
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk("set byte", {24'h0, q[15:8]}, {31'h0, cond(c[3:0], v)});
    end
    for (int k = 0; k < 6; k++) begin
      v = (k == 0) ? 32'h0 : $random(seed);
      w = $random(seed);
      r = v & w;
      bus(1'b1, `OFS_OPA, v);
      bus(1'b1, `OFS_OPB, w);
      bus(1'b1, `OFS_FLAGS, 32'h8C7);
      run(32'h1);
      fl = 32'h803 | {r[31], r == 32'h0, 3'h0, ~^r[7:0], 2'h0};
      rchk("test flags", `OFS_FLAGS, fl);
      rchk("opa", `OFS_OPA, v);
      rchk("opb", `OFS_OPB, w);
    end
    n0 = n_req;
    ip = 32'h1000;
    fl = 32'h8C7;
    bus(1'b1, `OFS_IP, ip);
    bus(1'b1, `OFS_FLAGS, fl);
    bus(1'b1, `OFS_DISP, 32'hF0);
    run(32'h102);
    ip = ip - 32'h10;
    regs();
    run(32'h2);
    ip = ip + 32'hF0;
    regs();
    bus(1'b1, `OFS_TARGET, 32'h2468);
    run(32'h3);
    ip = 32'h2468;
    regs();
    bus(1'b1, `OFS_TARGET, 32'h2470);
    run(32'h4);
    ip = 32'h2470;
    regs();
    bus(1'b1, `OFS_SELECTOR, 32'h1234);
    bus(1'b1, `OFS_TARGET, 32'h3000);
    run(32'h5);
    cs = 32'h1234;
    ip = 32'h3000;
    regs();
    run(32'h4D);
    chk("taken", {31'h0, q[1]}, 32'h1);
    ip = ip + 32'hF0;
    regs();
    run(32'h5D);
    chk("not taken", {31'h0, q[1]}, 32'h0);
    regs();
    chk("no push", n_req, n0);
    bus(1'b1, `OFS_SELECTOR, 32'h77);
    for (int g = 1; g < 4; g++) begin
      bus(1'b1, `OFS_TARGET, 32'h4000 + g);
      run(32'h20E | (g << 10));
      if (g == 1) begin
        cs = 32'h77;
        ip = 32'h4001;
      end
      bus(1'b0, `OFS_STATUS, 32'h0);
      chk("gate", {30'h0, q[4:3]}, g);
      regs();
    end
    o = ip;
    bus(1'b1, `OFS_TARGET, 32'h5000);
    run(32'h7);
    sp = sp - 32'h4;
    ip = 32'h5000;
    chk("ret ptr", stk[sp], o);
    regs();
    run(32'h9);
    sp = sp + 32'h4;
    ip = o;
    regs();
    bus(1'b1, `OFS_SELECTOR, 32'hAB);
    bus(1'b1, `OFS_TARGET, 32'h6000);
    run(32'h8);
    chk("far cs", stk[sp - 32'h4], cs);
    chk("far ip", stk[sp - 32'h8], o);
    sp = sp - 32'h8;
    cs = 32'hAB;
    ip = 32'h6000;
    regs();
    bus(1'b1, `OFS_IMM, 32'h4);
    run(32'hA);
    sp = sp + 32'h8;
    ip = o;
    regs();
    run(32'h6);
    sp = sp - 32'h4;
    chk("rel ret ptr", stk[sp], o);
    ip = o + 32'hF0;
    regs();
    run(32'h9);
    sp = sp + 32'h4;
    ip = o;
    regs();
    bus(1'b1, `OFS_SELECTOR, 32'hCD);
    bus(1'b1, `OFS_TARGET, 32'h7000);
    run(32'hB);
    chk("int flags", stk[sp - 32'h4], fl);
    chk("int cs", stk[sp - 32'h8], cs);
    chk("int ip", stk[sp - 32'hC], ip);
    w = cs;
    sp = sp - 32'hC;
    cs = 32'hCD;
    ip = 32'h7000;
    regs();
    bus(1'b1, `OFS_FLAGS, 32'h2);
    run(32'hC);
    sp = sp + 32'hC;
    cs = w;
    ip = o;
    regs();
    conclude();
  end
endmodule // flag_test_and_branch_unit_tb
bind flag_test_and_branch_unit flag_test_and_branch_unit_checker chk_i (.hclk(hclk), .hresetn(hresetn),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .mem_req(mem_req), .mem_write(mem_write), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
  .mem_ack(mem_ack));
